// File: pkg/mlcs_defs.svh
// Purpose: constants of the monitor limit compare sequencer
// Assumes: 100 MHz mclk, 8-bit register port
// Notes:   times are in ns, cycle counts derive from them
`ifndef MLCS_DEFS_SVH
`define MLCS_DEFS_SVH

// clock and timing
`define MLCS_CLK_NS          10
`define MLCS_CONV_NS         11600000
`define MLCS_REMOTE_NS       34800000
`define MLCS_AVG_N           16
`define MLCS_AVG_SHIFT       4
`define MLCS_SUB_LAST        4'hF

// channels
`define MLCS_NCHAN           8
`define MLCS_CH_REMOTE       3'h6
`define MLCS_CH_LOCAL        3'h7

// register offsets
`define MLCS_VAL_BASE        8'h20
`define MLCS_LIM_BASE        8'h2B
`define MLCS_LIM_SPAN        8'h10
`define MLCS_CFG_ADDR        8'h40
`define MLCS_STAT1_ADDR      8'h41
`define MLCS_STAT2_ADDR      8'h42

// fields and reset values
`define MLCS_CFG_START_BIT   0
`define MLCS_STAT2_FAULT_BIT 6
`define MLCS_RST_BYTE        8'h00

`endif

// File: pkg/mlcs_pkg.sv
// Purpose: types of the monitor limit compare sequencer
// Assumes: constants live in mlcs_defs.svh
// Notes:   no timescale, nothing imported elsewhere
package mlcs_pkg;

  typedef enum logic [2:0] {
    MLCS_IDLE,
    MLCS_START,
    MLCS_WAITD,
    MLCS_HOLD,
    MLCS_STORE
  } mlcs_state_t;

  typedef logic [7:0] mlcs_byte_t;
  typedef logic [2:0] mlcs_chan_t;

endpackage

// File: rtl/mlcs_limit_cmp.sv
// Purpose: window compare of one result against its limits
// Assumes: limits and value are 8-bit
// Notes:   combinational, signed or unsigned per channel
`timescale 1ns/100ps
module mlcs_limit_cmp #(
  parameter int DW = 8
) (
  // operands
  input  wire logic [DW-1:0] value,
  input  wire logic [DW-1:0] hiLim,
  input  wire logic [DW-1:0] loLim,
  input  wire logic          signedCmp,
  // result
  output logic               outOfLimit
);

  // a greater than b, signed or unsigned
  function automatic logic gtSel(input logic [DW-1:0] a, input logic [DW-1:0] b,
                                 input logic sgn);
    if (sgn) begin
      return $signed(a) > $signed(b);
    end
    return a > b;
  endfunction

  always_comb begin
    outOfLimit = gtSel(value, hiLim, signedCmp) || gtSel(loLim, value, signedCmp);
  end

endmodule

// File: rtl/mlcs_avg16.sv
// Purpose: running sum of remote samples, floor average out
// Assumes: samples are two's complement bytes
// Notes:   clr wins over add in the same cycle
`timescale 1ns/100ps
`include "mlcs_defs.svh"
module mlcs_avg16 #(
  parameter int DW    = 8,
  parameter int SHIFT = `MLCS_AVG_SHIFT
) (
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst_n,
  // control
  input  wire logic          clr,
  input  wire logic          add,
  input  wire logic [DW-1:0] din,
  // result
  output logic      [DW-1:0] avg
);

  logic signed [DW+SHIFT-1:0] sum_r;
  logic signed [DW+SHIFT-1:0] sum_nxt;

  always_comb begin
    sum_nxt = sum_r;
    if (clr) begin
      sum_nxt = '0;
    end else if (add) begin
      sum_nxt = sum_r + (DW+SHIFT)'($signed(din));
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sum_r <= '0;
    end else begin
      sum_r <= sum_nxt;
    end
  end

  // arithmetic shift: sum of 16 two's complement samples
  assign avg = sum_r[DW+SHIFT-1:SHIFT];

endmodule

// File: rtl/mlcs_seq_top.sv
// Purpose: round-robin measurement sequencer with limit checks
// Assumes: external converter answers adcStart with one adcDone pulse
// Notes:   register port is a simple synchronous byte port
`timescale 1ns/100ps
`include "mlcs_defs.svh"
module mlcs_seq_top #(
  parameter int CNT_W      = 22,
  parameter int CONV_CYC   = `MLCS_CONV_NS / `MLCS_CLK_NS,
  parameter int REMOTE_CYC = `MLCS_REMOTE_NS / `MLCS_CLK_NS
) (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // register port
  input  wire logic [7:0] regAddr,
  input  wire logic       regWr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  output logic            regRdValid,
  // converter
  output logic            adcStart,
  output logic      [2:0] adcChan,
  input  wire logic       adcDone,
  input  wire logic [7:0] adcData,
  // remote diode fault detectors
  input  wire logic       diodeGndShort,
  input  wire logic       diodeSupShort,
  input  wire logic       diodePairShort,
  input  wire logic       diodePairOpen,
  // interrupt sources and state
  output logic            tempAlarm,
  output logic            voltAlarm,
  output logic            running
);

  localparam int SUB_CYC = REMOTE_CYC / `MLCS_AVG_N;

  function automatic logic isTemp(input mlcs_pkg::mlcs_chan_t c);
    return (c == `MLCS_CH_REMOTE) || (c == `MLCS_CH_LOCAL);
  endfunction

  function automatic logic isValAddr(input logic [7:0] a);
    return a[7:3] == 5'(`MLCS_VAL_BASE >> 3);
  endfunction

  function automatic logic isLimAddr(input logic [7:0] a);
    return (a >= `MLCS_LIM_BASE) && (a < `MLCS_LIM_BASE + `MLCS_LIM_SPAN);
  endfunction

  // sequencer state
  mlcs_pkg::mlcs_state_t state_r, state_nxt;
  mlcs_pkg::mlcs_chan_t  chan_r, chan_nxt;
  logic [3:0]            sub_r, sub_nxt;
  logic [CNT_W-1:0]      cnt_r, cnt_nxt;
  logic [CNT_W-1:0]      lastCnt;
  logic                  faultAcc_r, faultAcc_nxt;
  logic [7:0]            sample_r, sample_nxt;
  logic                  storeEn;
  logic                  avgClr;
  logic                  avgAdd;
  logic                  chanRemote;
  logic                  diodeFault;
  logic [7:0]            avgOut;
  logic [7:0]            storeVal;
  logic                  cmpOut;

  // register file
  logic                              cfgStart_r, cfgStart_nxt;
  logic [`MLCS_NCHAN-1:0][7:0]       value_r, value_nxt;
  logic [`MLCS_NCHAN-1:0][7:0]       hiLim_r, hiLim_nxt;
  logic [`MLCS_NCHAN-1:0][7:0]       loLim_r, loLim_nxt;
  logic [7:0]                        status1_r, status1_nxt;
  logic [7:0]                        status2_r, status2_nxt;
  logic                              tempAlarm_r, tempAlarm_nxt;
  logic                              voltAlarm_r, voltAlarm_nxt;
  logic [7:0]                        limOff;
  logic [7:0]                        rdData_r, rdData_nxt;
  logic                              rdValid_r;

  assign chanRemote = (chan_r == `MLCS_CH_REMOTE);
  assign diodeFault = diodeGndShort | diodeSupShort | diodePairShort | diodePairOpen;
  assign storeVal   = chanRemote ? avgOut : sample_r;
  assign limOff     = regAddr - `MLCS_LIM_BASE;

  mlcs_avg16 u_avg (
    .mclk  (mclk),
    .rst_n (rst_n),
    .clr   (avgClr),
    .add   (avgAdd),
    .din   (adcData),
    .avg   (avgOut)
  );

  mlcs_limit_cmp u_cmp (
    .value      (storeVal),
    .hiLim      (hiLim_r[chan_r]),
    .loLim      (loLim_r[chan_r]),
    .signedCmp  (isTemp(chan_r)),
    .outOfLimit (cmpOut)
  );

  // slot length: last remote sub-slot and plain slots leave a cycle for the store
  always_comb begin
    if (chanRemote) begin
      lastCnt = (sub_r == `MLCS_SUB_LAST) ? CNT_W'(SUB_CYC - 2) : CNT_W'(SUB_CYC - 1);
    end else begin
      lastCnt = CNT_W'(CONV_CYC - 2);
    end
  end

  // sequencer next state
  always_comb begin
    state_nxt    = state_r;
    chan_nxt     = chan_r;
    sub_nxt      = sub_r;
    cnt_nxt      = cnt_r + CNT_W'(1);
    faultAcc_nxt = faultAcc_r | (chanRemote & diodeFault);
    sample_nxt   = sample_r;
    adcStart     = 1'b0;
    storeEn      = 1'b0;
    avgClr       = 1'b0;
    avgAdd       = 1'b0;
    case (state_r)
      mlcs_pkg::MLCS_IDLE: begin
        cnt_nxt      = '0;
        faultAcc_nxt = 1'b0;
        if (cfgStart_r) begin
          chan_nxt  = '0;
          sub_nxt   = '0;
          avgClr    = 1'b1;
          state_nxt = mlcs_pkg::MLCS_START;
        end
      end
      mlcs_pkg::MLCS_START: begin
        adcStart  = 1'b1;
        state_nxt = mlcs_pkg::MLCS_WAITD;
      end
      mlcs_pkg::MLCS_WAITD: begin
        if (!cfgStart_r) begin
          state_nxt = mlcs_pkg::MLCS_IDLE;
        end else if (adcDone) begin
          sample_nxt = adcData;
          avgAdd     = chanRemote;
          state_nxt  = mlcs_pkg::MLCS_HOLD;
        end
      end
      mlcs_pkg::MLCS_HOLD: begin
        if (!cfgStart_r) begin
          state_nxt = mlcs_pkg::MLCS_IDLE;
        end else if (cnt_r >= lastCnt) begin
          cnt_nxt = '0;
          if (chanRemote && (sub_r != `MLCS_SUB_LAST)) begin
            sub_nxt   = sub_r + 4'h1;
            state_nxt = mlcs_pkg::MLCS_START;
          end else begin
            state_nxt = mlcs_pkg::MLCS_STORE;
          end
        end
      end
      mlcs_pkg::MLCS_STORE: begin
        storeEn      = 1'b1;
        avgClr       = 1'b1;
        faultAcc_nxt = 1'b0;
        sub_nxt      = '0;
        cnt_nxt      = '0;
        chan_nxt     = chan_r + 3'h1;
        state_nxt    = cfgStart_r ? mlcs_pkg::MLCS_START : mlcs_pkg::MLCS_IDLE;
      end
      default: begin
        state_nxt = mlcs_pkg::MLCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= mlcs_pkg::MLCS_IDLE;
      chan_r     <= '0;
      sub_r      <= '0;
      cnt_r      <= '0;
      faultAcc_r <= 1'b0;
      sample_r   <= `MLCS_RST_BYTE;
    end else begin
      state_r    <= state_nxt;
      chan_r     <= chan_nxt;
      sub_r      <= sub_nxt;
      cnt_r      <= cnt_nxt;
      faultAcc_r <= faultAcc_nxt;
      sample_r   <= sample_nxt;
    end
  end

  // register file next values
  always_comb begin
    cfgStart_nxt  = cfgStart_r;
    value_nxt     = value_r;
    hiLim_nxt     = hiLim_r;
    loLim_nxt     = loLim_r;
    status1_nxt   = status1_r;
    status2_nxt   = status2_r;
    tempAlarm_nxt = 1'b0;
    voltAlarm_nxt = 1'b0;
    if (regWr) begin
      if (regAddr == `MLCS_CFG_ADDR) begin
        cfgStart_nxt = regWrData[`MLCS_CFG_START_BIT];
      end else if (isLimAddr(regAddr)) begin
        if (limOff[0]) begin
          loLim_nxt[limOff[3:1]] = regWrData;
        end else begin
          hiLim_nxt[limOff[3:1]] = regWrData;
        end
      end
    end
    if (storeEn) begin
      value_nxt[chan_r]   = storeVal;
      status1_nxt[chan_r] = cmpOut;
      if (chanRemote) begin
        status2_nxt[`MLCS_STAT2_FAULT_BIT] = faultAcc_r;
      end
      tempAlarm_nxt = cmpOut & isTemp(chan_r);
      voltAlarm_nxt = cmpOut & ~isTemp(chan_r);
    end
  end

  // read path, no side effects on status
  always_comb begin
    rdData_nxt = `MLCS_RST_BYTE;
    if (isValAddr(regAddr)) begin
      rdData_nxt = value_r[regAddr[2:0]];
    end else if (isLimAddr(regAddr)) begin
      rdData_nxt = limOff[0] ? loLim_r[limOff[3:1]] : hiLim_r[limOff[3:1]];
    end else if (regAddr == `MLCS_CFG_ADDR) begin
      rdData_nxt[`MLCS_CFG_START_BIT] = cfgStart_r;
    end else if (regAddr == `MLCS_STAT1_ADDR) begin
      rdData_nxt = status1_r;
    end else if (regAddr == `MLCS_STAT2_ADDR) begin
      rdData_nxt = status2_r;
    end
    if (!regRd) begin
      rdData_nxt = rdData_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfgStart_r  <= 1'b0;
      value_r     <= {`MLCS_NCHAN{`MLCS_RST_BYTE}};
      hiLim_r     <= {`MLCS_NCHAN{`MLCS_RST_BYTE}};
      loLim_r     <= {`MLCS_NCHAN{`MLCS_RST_BYTE}};
      status1_r   <= `MLCS_RST_BYTE;
      status2_r   <= `MLCS_RST_BYTE;
      tempAlarm_r <= 1'b0;
      voltAlarm_r <= 1'b0;
      rdData_r    <= `MLCS_RST_BYTE;
      rdValid_r   <= 1'b0;
    end else begin
      cfgStart_r  <= cfgStart_nxt;
      value_r     <= value_nxt;
      hiLim_r     <= hiLim_nxt;
      loLim_r     <= loLim_nxt;
      status1_r   <= status1_nxt;
      status2_r   <= status2_nxt;
      tempAlarm_r <= tempAlarm_nxt;
      voltAlarm_r <= voltAlarm_nxt;
      rdData_r    <= rdData_nxt;
      rdValid_r   <= regRd;
    end
  end

  assign regRdData  = rdData_r;
  assign regRdValid = rdValid_r;
  assign adcChan    = chan_r;
  assign tempAlarm  = tempAlarm_r;
  assign voltAlarm  = voltAlarm_r;
  assign running    = (state_r != mlcs_pkg::MLCS_IDLE);

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_fault_bit;
    (storeEn && chanRemote) |=> (status2_r[`MLCS_STAT2_FAULT_BIT] == $past(faultAcc_r));
  endproperty
  a_fault_bit: assert property (p_fault_bit) else $error("fault bit not updated");

  property p_status_set;
    (storeEn && cmpOut) |=> status1_r[$past(chan_r)];
  endproperty
  a_status_set: assert property (p_status_set) else $error("status not set");

  property p_status_clr;
    (storeEn && !cmpOut) |=> !status1_r[$past(chan_r)];
  endproperty
  a_status_clr: assert property (p_status_clr) else $error("status not cleared");

  property p_read_keeps;
    (regRd && !storeEn) |=> ($stable(status1_r) && $stable(status2_r));
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read altered status");

  property p_no_start_idle;
    (!cfgStart_r && state_r == mlcs_pkg::MLCS_IDLE) |-> !adcStart;
  endproperty
  a_no_start_idle: assert property (p_no_start_idle) else $error("conversion while stopped");

  property p_value_store;
    (storeEn && !chanRemote) |=> (value_r[$past(chan_r)] == $past(sample_r));
  endproperty
  a_value_store: assert property (p_value_store) else $error("value not stored");

  property p_stop;
    (regWr && regAddr == `MLCS_CFG_ADDR && !regWrData[`MLCS_CFG_START_BIT])
      |-> ##[1:3] (state_r == mlcs_pkg::MLCS_IDLE);
  endproperty
  a_stop: assert property (p_stop) else $error("sequence did not stop");

  property p_rd_valid;
    regRdValid == $past(regRd);
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read answer missing");

  property p_alarm;
    (storeEn && cmpOut) |=> (tempAlarm ^ voltAlarm);
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm pulse missing");

  property p_avg16;
    (storeEn && chanRemote) |-> (sub_r == `MLCS_SUB_LAST);
  endproperty
  a_avg16: assert property (p_avg16) else $error("remote stored before 16 samples");

  property p_slot_len;
    (state_r == mlcs_pkg::MLCS_HOLD && state_nxt == mlcs_pkg::MLCS_STORE)
      |-> (cnt_r >= lastCnt);
  endproperty
  a_slot_len: assert property (p_slot_len) else $error("slot ended early");

  c_remote_store: cover property (storeEn && chanRemote);
  c_fault: cover property (storeEn && chanRemote && faultAcc_r);
  c_temp_alarm: cover property (tempAlarm);
  c_stop: cover property (state_r == mlcs_pkg::MLCS_HOLD && !cfgStart_r);

endmodule

// File: testbench/mlcs_adc_model.sv
// Purpose: converter stand-in, one done pulse per start
// Assumes: answer comes at least four cycles before a remote sub-slot ends
// Notes:   data bus shows inverted last value when not answering
`timescale 1ns/100ps
module mlcs_adc_model (
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // sequencer side
  input  wire logic       adcStart,
  output logic            adcDone,
  output logic      [7:0] adcData,
  // bench control
  input  wire logic       slow,
  input  wire logic [7:0] dataIn
);
  int         waitCnt;
  logic [7:0] held;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 0;
      adcDone <= 1'b0;
      adcData <= 8'h00;
      held    <= 8'h00;
    end else begin
      adcDone <= 1'b0;
      adcData <= ~held;
      if (adcStart) begin
        held    <= dataIn;
        waitCnt <= slow ? 5 : 1;
      end else if (waitCnt > 0) begin
        waitCnt <= waitCnt - 1;
        if (waitCnt == 1) begin
          adcDone <= 1'b1;
          adcData <= held;
        end
      end
    end
  end
endmodule

// File: testbench/monitor_limit_compare_sequencer_tb_top.sv
// Purpose: self-checking bench of the measurement sequencer
// Assumes: short slot counts, converter model answers each start
// Notes:   reference model follows starts and dones at the ports
`timescale 1ns/100ps
`include "mlcs_defs.svh"
module monitor_limit_compare_sequencer_tb_top;
  localparam int         CONV = 40;
  localparam int         REM  = 160;
  localparam int         SUB  = REM / 16;
  localparam logic [7:0] RST_ADDR [9] = '{8'h20, 8'h26, 8'h27, 8'h2B, 8'h3A,
                                         8'h40, 8'h41, 8'h42, 8'hFF};
  logic       mclk, rst_n, regWr, regRd, slow, regRdValid;
  logic       adcStart, adcDone, tempAlarm, voltAlarm, running, haveStart, remFault;
  logic [7:0] regAddr, regWrData, dataIn, regRdData, adcData, expS1, expS2;
  logic [7:0] lim [16];
  logic [2:0] adcChan;
  logic [3:0] fault;
  logic [1:0] expAl;
  int         miscompares, num_checks, cycles, seed, mode, commits, target;
  int         lastStart, prevCh, expCh, lastCh, v, r, i;
  int         expVal [8];
  int         samp [$];

  mlcs_seq_top #(.CONV_CYC(CONV), .REMOTE_CYC(REM)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .regAddr(regAddr), .regWr(regWr),
    .regWrData(regWrData), .regRd(regRd), .regRdData(regRdData),
    .regRdValid(regRdValid), .adcStart(adcStart), .adcChan(adcChan),
    .adcDone(adcDone), .adcData(adcData), .diodeGndShort(fault[0]),
    .diodeSupShort(fault[1]), .diodePairShort(fault[2]), .diodePairOpen(fault[3]),
    .tempAlarm(tempAlarm), .voltAlarm(voltAlarm), .running(running));

  mlcs_adc_model u_adc (.mclk(mclk), .rst_n(rst_n), .adcStart(adcStart),
    .adcDone(adcDone), .adcData(adcData), .slow(slow), .dataIn(dataIn));

  task automatic close_out();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      miscompares++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  function automatic int sx(input int b, input bit sg);
    return (sg && b > 127) ? b - 256 : b;
  endfunction

  // store of the finished measurement in the reference model
  task automatic commit();
    int s;
    bit sg;
    bit outL;
    s = 0;
    foreach (samp[k]) s += samp[k];
    v = (prevCh == 6) ? ((s >>> 4) & 255) : (samp[0] & 255);
    sg = (prevCh >= 6);
    outL = sx(v, sg) > sx(int'(lim[2*prevCh]), sg) || sx(v, sg) < sx(int'(lim[2*prevCh+1]), sg);
    expVal[prevCh] = v;
    expS1[prevCh] = outL;
    if (prevCh == 6) expS2 = {1'b0, remFault, 6'h00};
    expAl = outL ? (sg ? 2'b10 : 2'b01) : 2'b00;
    lastCh = prevCh;
    commits++;
    samp.delete();
    remFault = 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge mclk);
    regWr     <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge mclk);
    regRd   <= 1'b0;
    #1;
    check(regRdValid === 1'b1 && regRdData === e, "register read");
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    dataIn <= (mode == 4) ? 8'h80 : (mode == 5) ? 8'h7F : 8'($random(seed));
  end

  // reference model and port monitor
  always @(posedge mclk) begin
    expAl = 2'b00;
    cycles = cycles + 1;
    if (cycles > 20000) begin
      miscompares++;
      close_out();
    end
    if (running !== 1'b1) begin
      haveStart = 1'b0;
      samp.delete();
      remFault = 1'b0;
      if (rst_n) check(adcStart === 1'b0, "start while stopped");
    end else begin
      if (|fault) remFault = 1'b1;
      if (adcDone === 1'b1) samp.push_back(sx(int'(adcData), 1'b1));
      if (adcStart === 1'b1) begin
        expCh = 0;
        if (haveStart) begin
          check(cycles - lastStart == ((prevCh == 6) ? SUB : CONV), "start spacing");
          expCh = (prevCh + 1) % 8;
          if (prevCh == 6 && samp.size() < 16) expCh = 6;
          else commit();
        end
        check(adcChan === 3'(expCh), "channel order");
        haveStart = 1'b1;
        lastStart = cycles;
        prevCh = expCh;
      end
    end
    if (rst_n) check({tempAlarm, voltAlarm} === expAl, "alarm pulse");
  end

  initial begin
    seed = 32'h20133B24;
    rst_n = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    dataIn = 8'h00;
    slow = 1'b0;
    fault = 4'h0;
    expS1 = 8'h00;
    expS2 = 8'h00;
    expAl = 2'b00;
    mode = 0;
    haveStart = 1'b0;
    remFault = 1'b0;
    foreach (expVal[k]) expVal[k] = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (RST_ADDR[k]) rd(RST_ADDR[k], 8'h00);
    wr(`MLCS_VAL_BASE, 8'h5A);
    rd(`MLCS_VAL_BASE, 8'h00);
    wr(`MLCS_STAT1_ADDR, 8'hFF);
    rd(`MLCS_STAT1_ADDR, 8'h00);
    for (r = 0; r < 6; r++) begin
      @(posedge mclk);
      fault <= (r >= 1 && r <= 4) ? 4'(1 << (r - 1)) : 4'h0;
      slow  <= r[0];
      mode = r;
      for (i = 0; i < 16; i++) begin
        lim[i] = 8'($random(seed));
        wr(8'(`MLCS_LIM_BASE + i), lim[i]);
      end
      rd(8'(`MLCS_LIM_BASE + 3), lim[3]);
      wr(`MLCS_CFG_ADDR, 8'h01);
      rd(`MLCS_CFG_ADDR, 8'h01);
      check(running === 1'b1, "sequencer idle after start");
      target = commits + 9;
      while (commits < target) @(posedge mclk);
      rd(8'(`MLCS_VAL_BASE + lastCh), 8'(expVal[lastCh]));
      wr(`MLCS_CFG_ADDR, 8'h00);
      while (running === 1'b1) @(posedge mclk);
      for (i = 0; i < 8; i++) rd(8'(`MLCS_VAL_BASE + i), 8'(expVal[i]));
      rd(`MLCS_STAT1_ADDR, expS1);
      rd(`MLCS_STAT1_ADDR, expS1);
      rd(`MLCS_STAT2_ADDR, expS2);
    end
    close_out();
  end
endmodule
